/* File: include/pme_pkg.sv */
// constants for the paged memory expansion
package pme_pkg;
  localparam logic [15:0] PME_SEGMENT_SELECT_ADDR = 16'h7fff;
  localparam logic [1:0]  PME_WINDOW_TAG          = 2'h1;
  localparam logic [7:0]  PME_SEGMENT_RESET       = 8'h00;
  localparam int          PME_SEG_LSB             = 0;
  localparam int          PME_CHIP_LSB            = 4;
  localparam int          PME_CHIP_CODES          = 8;
  localparam int          PME_RAM_FIRST           = 3;
  localparam int          PME_RAM_LAST            = 4;
  localparam int          PME_SYNC_STAGES         = 3;
endpackage

/* File: src/pme_chip_select_decoder.sv */
// one-of-eight chip enable decoder with ram power-fail gating
module pme_chip_select_decoder
  import pme_pkg::*;
(
  input  wire logic [2:0] code_in,
  input  wire logic       window_in,
  input  wire logic       power_ok_in,
  output logic [7:0]      enable_out
);
  genvar g;
  generate
    for (g = 0; g < PME_CHIP_CODES; g++)
    begin : g_dec
      if (g >= PME_RAM_FIRST && g <= PME_RAM_LAST)
      begin : g_ram
        // ram selects die on power-fail to protect backed data
        assign enable_out[g] = window_in && power_ok_in
                               && (code_in == 3'(g));
      end
      else
      begin : g_rom
        assign enable_out[g] = window_in && (code_in == 3'(g));
      end
    end
  endgenerate
endmodule // pme_chip_select_decoder

/* File: src/pme_paged_memory_expansion.sv */
// paged memory expansion: segment latch and memory select decode
// Contract
// - The board answers only to host accesses within 4000 to 7FFF.
// - The latch decode needs address bits 0 to 13 high in the window.
// - The window is selected when bit 14 is high and bit 15 is low.
// - The latch loads the data bus only on a write to the top address.
// - The latch holds its value until the next write to it.
// - Latch bits 0 and 1 drive memory address 14 and 15; 2, 3 ignored.
// - Latch bits 4 to 6 decode to eight chip enables; bit 7 ignored.
// - Only codes zero to four reach memories; others select none.
// - Each rom position spans four 16K segments.
// - Each ram position spans two 16K segments.
// - Ram selects are forced off while power-fail is signalled.
// - Address 0-13 and data 0-7 are buffered to memories and decode.
module pme_paged_memory_expansion
  import pme_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] host_addr_in,
  input  wire logic [7:0]  host_data_in,
  input  wire logic        host_write_in,
  input  wire logic        power_fail_in,
  output logic [13:0]      mem_addr_out,
  output logic [7:0]       mem_data_out,
  output logic [1:0]       mem_addr_high_out,
  output logic             memory_select_0_out,
  output logic             memory_select_1_out,
  output logic             memory_select_2_out,
  output logic             memory_select_3_out,
  output logic             memory_select_4_out,
  output logic             window_hit_out,
  output logic [7:0]       segment_select_out
);
  logic [7:0]  segment_latch_q;
  logic [13:0] addr_q;
  logic [7:0]  data_q;
  logic        window_q;
  logic        write_q;
  logic [PME_SYNC_STAGES-1:0] pf_sync_q;
  logic        power_ok_q;
  logic        region_sel;
  logic        top_decode;
  logic [7:0]  enables;

  // host bus registered once; host logic is on mclk
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      addr_q   <= 14'h0000;
      data_q   <= 8'h00;
      window_q <= 1'b0;
      write_q  <= 1'b0;
    end
    else
    begin
      addr_q   <= host_addr_in[13:0];
      data_q   <= host_data_in;
      window_q <= (host_addr_in[15:14] == PME_WINDOW_TAG);
      write_q  <= host_write_in;
    end
  end

  assign region_sel = window_q;
  assign top_decode = region_sel && (&addr_q);

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      segment_latch_q <= PME_SEGMENT_RESET;
    else if (top_decode && write_q)
      segment_latch_q <= data_q;
  end

  // power-fail is asynchronous; filtered by stage agreement
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pf_sync_q  <= '1;
      power_ok_q <= 1'b0;
    end
    else
    begin
      pf_sync_q <= {pf_sync_q[PME_SYNC_STAGES-2:0], power_fail_in};
      if (pf_sync_q[2] == pf_sync_q[1])
        power_ok_q <= !pf_sync_q[1];
    end
  end

  pme_chip_select_decoder u_chip_select_decoder (
    .code_in     (segment_latch_q[PME_CHIP_LSB +: 3]),
    .window_in   (region_sel && !top_decode),
    .power_ok_in (power_ok_q),
    .enable_out  (enables)
  );

  assign mem_addr_out        = addr_q;
  assign mem_data_out        = data_q;
  // roms use both bits, rams only bit 14 of 32K
  assign mem_addr_high_out   = segment_latch_q[PME_SEG_LSB +: 2];
  // codes 5..7 left undriven to any memory
  assign memory_select_0_out = enables[0];
  assign memory_select_1_out = enables[1];
  assign memory_select_2_out = enables[2];
  assign memory_select_3_out = enables[3];
  assign memory_select_4_out = enables[4];
  assign window_hit_out      = region_sel;
  assign segment_select_out  = segment_latch_q;
endmodule // pme_paged_memory_expansion

/* File: verif/pme_props.sv */
// port assertions for the paged memory expansion
module pme_props
  import pme_pkg::*;
(
  input wire logic        mclk_in, reset_in, host_write_in, power_fail_in,
  input wire logic [15:0] host_addr_in,
  input wire logic [7:0]  host_data_in, segment_select_out, mem_data_out,
  input wire logic [13:0] mem_addr_out,
  input wire logic [1:0]  mem_addr_high_out,
  input wire logic        window_hit_out, memory_select_0_out,
  input wire logic        memory_select_3_out, memory_select_4_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  window_hit_a: assert property (window_hit_out ==
    $past(host_addr_in[15:14] == 2'b01)) else $error("window hit wrong");
  latch_load_a: assert property (host_write_in && host_addr_in ==
    PME_SEGMENT_SELECT_ADDR |=> ##1 segment_select_out ==
    $past(host_data_in, 2)) else $error("latch not loaded");
  latch_hold_a: assert property (!$past(host_write_in &&
    host_addr_in == 16'h7fff, 2) |-> $stable(segment_select_out))
    else $error("latch changed");
  seg_bits_a: assert property (mem_addr_high_out ==
    segment_select_out[1:0]) else $error("segment bits wrong");
  bus_copy_a: assert property (mem_addr_out == $past(host_addr_in[13:0])
    && mem_data_out == $past(host_data_in)) else $error("bus copy wrong");
  ram_code_a: assert property (memory_select_3_out |-> window_hit_out &&
    segment_select_out[6:4] == 3'h3) else $error("select without code");
  ram_off_a: assert property (power_fail_in [*5] |->
    !memory_select_3_out && !memory_select_4_out) else $error("ram on");
  rom_sel_a: assert property (window_hit_out && mem_addr_out !=
    14'h3fff && segment_select_out[6:4] == 3'h0 |-> memory_select_0_out)
    else $error("rom select missing");
endmodule // pme_props
bind pme_paged_memory_expansion pme_props u_props (.*);

/* File: verif/pme_host.sv */
// host bus model driving the expansion inputs
module pme_host (
  input  wire logic        mclk_in,
  output logic      [15:0] addr_out,
  output logic      [7:0]  data_out,
  output logic             write_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_out, data_out, write_out} = '0;
  // one access per call; write is dropped at the next edge
  task acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk_in);
    addr_out <= a;
    data_out <= d;
    write_out <= w;
    @(posedge mclk_in);
    write_out <= 1'b0;
    #1;
  endtask
endmodule // pme_host

/* File: verif/tb_pme_paged_memory_expansion.sv */
// bench for the paged memory expansion
module tb_pme_paged_memory_expansion;
  import pme_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, reset_in = 1, power_fail_in = 0, w;
  logic [15:0] a;
  logic [7:0] d, seg;
  logic [4:0] s;
  logic [1:0] hi;
  logic       wh;
  int miscompares = 0, cmp_count = 0;
  pme_host H (.mclk_in(mclk_in), .addr_out(a), .data_out(d), .write_out(w));
  pme_paged_memory_expansion DUT (.mclk_in(mclk_in), .reset_in(reset_in),
    .host_addr_in(a), .host_data_in(d), .host_write_in(w),
    .power_fail_in(power_fail_in), .mem_addr_out(), .mem_data_out(),
    .mem_addr_high_out(hi), .memory_select_0_out(s[0]),
    .memory_select_1_out(s[1]), .memory_select_2_out(s[2]),
    .memory_select_3_out(s[3]), .memory_select_4_out(s[4]),
    .window_hit_out(wh), .segment_select_out(seg));
  initial forever #20 mclk_in = ~mclk_in;
  task chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) $display("[FAIL] %0t got %h exp %h", $time, g, e);
    if (g !== e) miscompares++;
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    #1 chk(seg, PME_SEGMENT_RESET);
    // junk in bits 2, 3 and 7 must not matter
    for (int c = 0; c < 8; c++)
    begin
      H.acc(PME_SEGMENT_SELECT_ADDR, {1'b1, 3'(c), 4'hc | 4'(c % 4)}, 1);
      H.acc(16'h4000, 8'h00, 0);
      chk({3'h0, s}, c < 5 ? 8'(1 << c) : 8'h00);
      chk({6'h00, hi}, 8'(c % 4));
      chk({7'h00, wh}, 8'h01);
    end
    $display("code walk done");
    H.acc(16'h7fff, 8'h00, 0);
    H.acc(16'h3fff, 8'h00, 1);
    chk(seg, 8'hff);
    chk({3'h0, s}, 8'h00);
    chk({7'h00, wh}, 8'h00);
    H.acc(16'h7fff, 8'h41, 1);
    power_fail_in <= 1'b1;
    H.acc(16'h4000, 8'h00, 0);
    repeat (4) @(posedge mclk_in);
    #1 chk({3'h0, s}, 8'h00);
    power_fail_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    #1 chk({3'h0, s}, 8'h10);
    $display("refusal and power tests done");
    give_verdict();
  end
  initial
  begin
    #20000 miscompares++;
    give_verdict();
  end
endmodule // tb_pme_paged_memory_expansion
